// File: hdl/smm_access_pkg.sv
// How it works
// - Open, closed and lock controls act only while the global enable is one.
// - Open set and lock clear make management DRAM visible without SMM decode.
// - Closed blocks data references to the compatible window; code still reaches it.
// - Closed affects only the compatible window, not high window or top segment.
// - Setting lock clears open and freezes lock, open, high, size, segment enable.
// - Lock is set by a normal write and cleared only by full reset.
// - Global enable maps 128 KB at A0000h for SMM; read-only once locked.
// - High window and top segment work only with the global enable set.
// - Base segment field is read-only, hardwired to 010, no remapping.
// - Processor compatible-window accesses failing the conditions go to the hub interface.
// - Global and high enables remap FEDA0000h-FEDBFFFFh onto A0000h-BFFFFh.
// - Non-SMM processor access to high window or top segment with open clear sets a flag.
// - The invalid-access flag stays set until software writes one to it.
// - Cacheable and both cache-enable indicators read as one, ignore writes.
// - Size code 10 selects 512 KB, code 11 selects 1 MB below usable top.
// - Top segment is reachable only from the processor, with SMM set or with open in effect.
// - Non-SMM top segment accesses go to the hub interface when enabled and open is not in effect.
// - Top segment appears only with global and segment enable; frozen by lock.
// - As management memory, the compatible window refuses hub and graphics port.
package smm_access_pkg;

    localparam logic [7:0] compat_control_off = 8'h9d;
    localparam logic [7:0] extended_control_off = 8'h9e;
    localparam logic [7:0] compat_control_reset = 8'h02;
    localparam logic [7:0] extended_control_reset = 8'h38;

    localparam int open_bit = 6;
    localparam int closed_bit = 5;
    localparam int lock_bit = 4;
    localparam int global_bit = 3;
    localparam logic [2:0] compat_base_segment = 3'h2;

    localparam int high_bit = 7;
    localparam int flag_bit = 6;
    localparam int size_hi = 2;
    localparam int size_lo = 1;
    localparam int seg_en_bit = 0;
    localparam logic [2:0] cache_indicators = 3'h7;

    localparam logic [31:0] compat_lo = 32'h000a0000;
    localparam logic [31:0] compat_hi = 32'h000bffff;
    localparam logic [31:0] high_lo = 32'hfeda0000;
    localparam logic [31:0] high_hi = 32'hfedbffff;
    localparam logic [31:0] size_512k = 32'h00080000;
    localparam logic [31:0] size_1m = 32'h00100000;
    localparam logic [1:0] size_code_512k = 2'h2;
    localparam logic [1:0] size_code_1m = 2'h3;

    typedef enum logic [1:0] {
        src_processor,
        src_hub,
        src_graphics
    } source_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        source_t source;
        logic smm;
        logic code;
    } request_t;

    typedef struct packed {
        logic valid;
        logic to_dram;
        logic to_hub;
        logic denied;
        logic [31:0] dram_addr;
    } decision_t;

    typedef struct packed {
        logic open;
        logic closed;
        logic lock;
        logic global_en;
        logic high_en;
        logic [1:0] size;
        logic seg_en;
    } controls_t;

endpackage

// File: hdl/smm_route_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module smm_route_decoder (
    // Request and control state
    input wire smm_access_pkg::request_t i_request,
    input wire smm_access_pkg::controls_t i_controls,
    input wire logic [31:0] i_top_of_usable_dram,
    // Decision
    output var smm_access_pkg::decision_t o_decision,
    output logic o_invalid
);
    import smm_access_pkg::*;

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic [31:0] seg_size;
    logic [31:0] seg_base;
    logic hit_compat;
    logic hit_high;
    logic hit_seg;
    logic open_eff;
    logic closed_eff;
    logic compat_ok;
    logic high_on;
    logic seg_on;

    always_comb begin
        // Reserved size codes leave the segment empty.
        case (i_controls.size)
            size_code_512k: seg_size = size_512k;
            size_code_1m: seg_size = size_1m;
            default: seg_size = 32'h0;
        endcase
        seg_base = i_top_of_usable_dram - seg_size;
        // Open wins over closed so a misprogrammed pair still decides one way.
        open_eff = i_controls.global_en && i_controls.open && !i_controls.lock;
        closed_eff = i_controls.global_en && i_controls.closed && !open_eff;
        high_on = i_controls.global_en && i_controls.high_en;
        seg_on = i_controls.global_en && i_controls.seg_en && (seg_size != 32'h0);
        hit_compat = in_range(i_request.addr, compat_lo, compat_hi);
        hit_high = high_on && in_range(i_request.addr, high_lo, high_hi);
        hit_seg = seg_on && (i_request.addr >= seg_base)
            && (i_request.addr < i_top_of_usable_dram);
        compat_ok = i_request.source == src_processor && i_controls.global_en
            && (open_eff || (i_request.smm && (!closed_eff || i_request.code)));
        o_decision.valid = i_request.valid;
        o_decision.dram_addr = i_request.addr;
        o_decision.to_dram = 1'b0;
        o_decision.to_hub = 1'b0;
        o_decision.denied = 1'b0;
        o_invalid = 1'b0;
        if (hit_compat) begin
            if (compat_ok) begin
                o_decision.to_dram = 1'b1;
            end else if (i_request.source != src_processor && i_controls.global_en) begin
                o_decision.denied = 1'b1;
            end else begin
                o_decision.to_hub = 1'b1;
            end
        end else if (hit_high || hit_seg) begin
            // Closed is deliberately ignored here.
            if (i_request.source == src_processor && (i_request.smm || open_eff)) begin
                o_decision.to_dram = 1'b1;
                if (hit_high) begin
                    o_decision.dram_addr = i_request.addr - high_lo + compat_lo;
                end
            end else begin
                o_decision.to_hub = 1'b1;
            end
            o_invalid = i_request.valid && i_request.source == src_processor
                && !i_request.smm && !i_controls.open;
        end else begin
            o_decision.to_dram = 1'b1;
        end
    end

endmodule // smm_route_decoder
`default_nettype wire

// File: hdl/smm_ram_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module smm_ram_access_control (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Configuration access
    input wire logic i_cfg_write,
    input wire logic i_cfg_read,
    input wire logic [7:0] i_cfg_offset,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // Memory map inputs
    input wire logic [31:0] i_top_of_usable_dram,
    // Request and decision
    input wire smm_access_pkg::request_t i_request,
    output var smm_access_pkg::decision_t o_decision,
    output logic o_invalid_access_flag
);
    import smm_access_pkg::*;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    controls_t ctl_q;
    logic flag_q;
    decision_t dec_d;
    logic invalid_d;
    logic wr_compat;
    logic wr_ext;
    logic [7:0] compat_view;
    logic [7:0] ext_view;
    logic lock_now;

    assign wr_compat = i_cfg_write && i_cfg_offset == compat_control_off;
    // A lock written while the global enable goes low is ignored, so it cannot freeze an off map.
    assign lock_now = i_cfg_wdata[lock_bit] && i_cfg_wdata[global_bit];
    assign wr_ext = i_cfg_write && i_cfg_offset == extended_control_off;

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ctl_q <= '0;
        end else begin
            if (wr_compat && !ctl_q.lock) begin
                ctl_q.closed <= i_cfg_wdata[closed_bit];
                ctl_q.global_en <= i_cfg_wdata[global_bit];
                // Lock drops the open bit in the same write that sets it.
                ctl_q.open <= i_cfg_wdata[open_bit] && !lock_now;
                ctl_q.lock <= lock_now;
            end else if (wr_compat) begin
                ctl_q.closed <= i_cfg_wdata[closed_bit];
            end
            if (wr_ext && !ctl_q.lock) begin
                ctl_q.high_en <= i_cfg_wdata[high_bit];
                ctl_q.size <= i_cfg_wdata[size_hi:size_lo];
                ctl_q.seg_en <= i_cfg_wdata[seg_en_bit];
            end
        end
    end

    // ----------------------------------------------------------------
    // Invalid-access flag
    // ----------------------------------------------------------------
    // A new violation in the clearing cycle wins, so no event is lost.
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            flag_q <= 1'b0;
        end else if (invalid_d) begin
            flag_q <= 1'b1;
        end else if (wr_ext && i_cfg_wdata[flag_bit]) begin
            flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    assign compat_view = {1'b0, ctl_q.open, ctl_q.closed, ctl_q.lock, ctl_q.global_en,
        compat_base_segment};
    assign ext_view = {ctl_q.high_en, flag_q, cache_indicators, ctl_q.size,
        ctl_q.seg_en};

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_cfg_rdata <= 8'h0;
            o_cfg_rvalid <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg_read;
            if (i_cfg_read && i_cfg_offset == compat_control_off) begin
                o_cfg_rdata <= compat_view;
            end else if (i_cfg_read && i_cfg_offset == extended_control_off) begin
                o_cfg_rdata <= ext_view;
            end else begin
                o_cfg_rdata <= 8'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Routing
    // ----------------------------------------------------------------
    smm_route_decoder route (
        .i_request(i_request),
        .i_controls(ctl_q),
        .i_top_of_usable_dram(i_top_of_usable_dram),
        .o_decision(dec_d),
        .o_invalid(invalid_d)
    );

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_decision <= '0;
        end else begin
            o_decision <= dec_d;
        end
    end

    assign o_invalid_access_flag = flag_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // The checks decode the request a second time, apart from the decoder instance.
    function automatic logic in_window(input logic [31:0] a, input logic [31:0] lo,
                                       input logic [31:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [31:0] seg_span(input logic [1:0] code);
        case (code)
            size_code_512k: seg_span = size_512k;
            size_code_1m: seg_span = size_1m;
            default: seg_span = 32'h0;
        endcase
    endfunction

    logic req_proc;
    logic req_compat;
    logic req_high;
    logic req_seg;
    logic open_on;
    logic [31:0] seg_floor;

    assign seg_floor = i_top_of_usable_dram - seg_span(ctl_q.size);
    assign req_proc = i_request.valid && i_request.source == src_processor;
    assign req_compat = i_request.valid && in_window(i_request.addr, compat_lo, compat_hi);
    assign req_high = i_request.valid && in_window(i_request.addr, high_lo, high_hi);
    assign req_seg = i_request.valid && seg_span(ctl_q.size) != 32'h0
        && i_request.addr >= seg_floor && i_request.addr < i_top_of_usable_dram;
    assign open_on = ctl_q.global_en && ctl_q.open && !ctl_q.lock;

    chk_lock_sticky: assert property (@(posedge i_clock) disable iff (i_reset)
        ctl_q.lock |=> ctl_q.lock) else $error("lock bit cleared without reset");
    chk_lock_clears_open: assert property (@(posedge i_clock) disable iff (i_reset)
        ctl_q.lock |-> !ctl_q.open) else $error("open bit set while locked");
    chk_lock_freezes: assert property (@(posedge i_clock) disable iff (i_reset)
        ctl_q.lock |=> $stable(ctl_q.seg_en) && $stable(ctl_q.size) && $stable(ctl_q.high_en)
        && $stable(ctl_q.global_en)) else $error("locked field changed");
    chk_flag_holds: assert property (@(posedge i_clock) disable iff (i_reset)
        flag_q && !(wr_ext && i_cfg_wdata[flag_bit]) |=> flag_q)
        else $error("flag dropped without a clear");
    chk_flag_sets: assert property (@(posedge i_clock) disable iff (i_reset)
        invalid_d |=> flag_q) else $error("violation not flagged");
    chk_compat_read: assert property (@(posedge i_clock) disable iff (i_reset)
        i_cfg_read && i_cfg_offset == compat_control_off |=> o_cfg_rdata[2:0] == 3'h2)
        else $error("base segment not 010");
    chk_cache_read: assert property (@(posedge i_clock) disable iff (i_reset)
        i_cfg_read && i_cfg_offset == extended_control_off |=> o_cfg_rdata[5:3] == 3'h7)
        else $error("cache indicators not one");
    chk_global_gate: assert property (@(posedge i_clock) disable iff (i_reset)
        i_request.valid && !ctl_q.global_en && i_request.addr >= compat_lo
        && i_request.addr <= compat_hi |=> o_decision.to_hub)
        else $error("compatible window reached DRAM while disabled");
    chk_lock_gated: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_compat && !ctl_q.lock && !i_cfg_wdata[global_bit] |=> !ctl_q.lock)
        else $error("lock took effect with the global enable low");
    chk_lock_set: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_compat && !ctl_q.lock && i_cfg_wdata[lock_bit] && i_cfg_wdata[global_bit]
        |=> ctl_q.lock && !ctl_q.open)
        else $error("locking write did not lock or left open set");
    chk_open_reaches: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && req_proc && open_on |=> o_decision.to_dram)
        else $error("open window did not reach DRAM");
    chk_open_wins: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && req_proc && open_on && ctl_q.closed |=> o_decision.to_dram)
        else $error("closed won over open");
    chk_closed_data: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && req_proc && ctl_q.global_en && ctl_q.closed && !open_on
        && i_request.smm && !i_request.code |=> o_decision.to_hub)
        else $error("closed window let a data reference through");
    chk_closed_code: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && req_proc && ctl_q.global_en && ctl_q.closed && !open_on
        && i_request.smm && i_request.code |=> o_decision.to_dram)
        else $error("closed window refused a code reference");
    chk_smm_compat: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && req_proc && ctl_q.global_en && !ctl_q.closed && i_request.smm
        |=> o_decision.to_dram)
        else $error("management access missed DRAM");
    chk_compat_forward: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && req_proc && !i_request.smm && !open_on |=> o_decision.to_hub)
        else $error("plain access did not go to the hub interface");
    chk_compat_denied: assert property (@(posedge i_clock) disable iff (i_reset)
        req_compat && !req_proc && ctl_q.global_en
        |=> o_decision.denied && !o_decision.to_dram)
        else $error("hub or graphics access reached management memory");
    chk_high_remap: assert property (@(posedge i_clock) disable iff (i_reset)
        req_high && req_proc && i_request.smm && ctl_q.global_en && ctl_q.high_en
        |=> o_decision.to_dram
        && o_decision.dram_addr == $past(i_request.addr) - high_lo + compat_lo)
        else $error("high window not remapped");
    chk_closed_ignored: assert property (@(posedge i_clock) disable iff (i_reset)
        req_high && req_proc && i_request.smm && ctl_q.global_en && ctl_q.high_en
        && ctl_q.closed |=> o_decision.to_dram)
        else $error("closed bit changed the high window");
    chk_high_gate: assert property (@(posedge i_clock) disable iff (i_reset)
        req_high && !(ctl_q.global_en && ctl_q.high_en)
        |=> o_decision.dram_addr == $past(i_request.addr))
        else $error("high window remapped while disabled");
    chk_seg_smm: assert property (@(posedge i_clock) disable iff (i_reset)
        req_seg && req_proc && i_request.smm && ctl_q.global_en && ctl_q.seg_en
        && !req_compat |=> o_decision.to_dram)
        else $error("management access missed the top segment");
    chk_seg_forward: assert property (@(posedge i_clock) disable iff (i_reset)
        req_seg && ctl_q.global_en && ctl_q.seg_en && !req_compat && !i_request.smm
        && !open_on |=> o_decision.to_hub)
        else $error("plain access reached the top segment");
    chk_seg_gate: assert property (@(posedge i_clock) disable iff (i_reset)
        req_seg && !(ctl_q.global_en && ctl_q.seg_en) && !req_compat && !req_high
        |=> o_decision.to_dram)
        else $error("disabled top segment still claimed the access");
    chk_flag_event: assert property (@(posedge i_clock) disable iff (i_reset)
        req_proc && !i_request.smm && !ctl_q.open && !req_compat && ctl_q.global_en
        && ((req_high && ctl_q.high_en) || (req_seg && ctl_q.seg_en)) |=> flag_q)
        else $error("invalid access not flagged");
    chk_flag_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        wr_ext && i_cfg_wdata[flag_bit] && !invalid_d |=> !flag_q)
        else $error("flag survived a clearing write");

endmodule // smm_ram_access_control
`default_nettype wire

// File: bench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock
    input wire logic i_clock,
    // Request toward the block
    output var smm_access_pkg::request_t o_request
);
    import smm_access_pkg::*;
    // A released bus drops valid and inverts address, SMM and code but keeps the source, so that a stale address never looks valid.
    task automatic send(input logic [31:0] a, input source_t s, input logic smm,
                        input logic code);
        @(negedge i_clock);
        o_request = '{valid: 1'b1, addr: a, source: s, smm: smm, code: code};
        @(negedge i_clock);
        o_request = '{valid: 1'b0, addr: ~a, source: s, smm: ~smm, code: ~code};
    endtask
    initial o_request = '0;
endmodule // host_bus_model
`default_nettype wire

// File: bench/test_smm_ram_access_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_smm_ram_access_control;
    import smm_access_pkg::*;
    localparam logic [2:0] dram = 3'h4;
    localparam logic [2:0] hub = 3'h2;
    localparam logic [2:0] deny = 3'h1;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_cfg_write = 1'b0;
    logic i_cfg_read = 1'b0;
    logic [7:0] i_cfg_offset = 8'h00;
    logic [7:0] i_cfg_wdata = 8'h00;
    logic [31:0] top = 32'h10000000;
    logic [7:0] rdata;
    logic rvalid;
    logic flag;
    request_t req;
    decision_t dec;
    int err_total = 0;
    int checks = 0;
    always #2 i_clock = ~i_clock;
    host_bus_model bus (.i_clock(i_clock), .o_request(req));
    smm_ram_access_control dut (.i_clock(i_clock), .i_reset(i_reset),
        .i_cfg_write(i_cfg_write), .i_cfg_read(i_cfg_read), .i_cfg_offset(i_cfg_offset),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_top_of_usable_dram(top), .i_request(req), .o_decision(dec),
        .o_invalid_access_flag(flag));
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_route(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t route %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t word %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        @(negedge i_clock);
        i_cfg_write = 1'b1;
        i_cfg_offset = off;
        i_cfg_wdata = d;
        @(negedge i_clock);
        i_cfg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] off, input logic [7:0] exp);
        @(negedge i_clock);
        i_cfg_read = 1'b1;
        i_cfg_offset = off;
        @(negedge i_clock);
        i_cfg_read = 1'b0;
        cmp_reg({7'h00, rvalid}, 8'h01);
        cmp_reg(rdata, exp);
    endtask
    task automatic rq(input logic [31:0] a, input source_t s, input logic smm,
                      input logic code, input logic [2:0] exp);
        bus.send(a, s, smm, code);
        cmp_reg({7'h00, dec.valid}, 8'h01);
        cmp_route({dec.to_dram, dec.to_hub, dec.denied}, exp);
    endtask
    task automatic reset_values;
        rd(8'h9d, 8'h02);
        wr(8'h9d, 8'h17);
        rd(8'h9d, 8'h02);
        wr(8'h9e, 8'h00);
        rd(8'h9e, 8'h38);
    endtask
    task automatic global_gate;
        wr(8'h9d, 8'h40);
        rq(32'h000a0000, src_processor, 1'b0, 1'b0, hub);
        rq(32'h000a0000, src_processor, 1'b1, 1'b0, hub);
        wr(8'h9d, 8'h08);
        rq(32'h000bffff, src_processor, 1'b1, 1'b0, dram);
        cmp_word(dec.dram_addr, 32'h000bffff);
        rq(32'h000a0000, src_processor, 1'b0, 1'b0, hub);
        rq(32'h000a0000, src_hub, 1'b1, 1'b0, deny);
        rq(32'h000b0000, src_graphics, 1'b1, 1'b0, deny);
    endtask
    task automatic open_closed;
        wr(8'h9d, 8'h48);
        rq(32'h000a0000, src_processor, 1'b0, 1'b0, dram);
        wr(8'h9d, 8'h28);
        rq(32'h000a0000, src_processor, 1'b1, 1'b0, hub);
        rq(32'h000a0000, src_processor, 1'b1, 1'b1, dram);
        // Both bits set on purpose to see which one wins.
        wr(8'h9d, 8'h68);
        rq(32'h000a0000, src_processor, 1'b0, 1'b0, dram);
    endtask
    task automatic high_window;
        wr(8'h9d, 8'h28);
        wr(8'h9e, 8'h80);
        rq(32'hfeda1234, src_processor, 1'b1, 1'b0, dram);
        cmp_word(dec.dram_addr, 32'h000a1234);
        bus.send(32'hfeda0000, src_processor, 1'b0, 1'b0);
        cmp_word({31'h0, flag}, 32'h1);
        rd(8'h9e, 8'hf8);
        wr(8'h9e, 8'h80);
        rd(8'h9e, 8'hf8);
        wr(8'h9e, 8'hc0);
        rd(8'h9e, 8'hb8);
        wr(8'h9d, 8'h00);
        bus.send(32'hfeda0000, src_processor, 1'b0, 1'b0);
        cmp_word({31'h0, flag}, 32'h0);
    endtask
    task automatic top_segment;
        wr(8'h9d, 8'h08);
        wr(8'h9e, 8'h05);
        rq(32'h0ff80000, src_processor, 1'b1, 1'b0, dram);
        rq(32'h0ff80000, src_processor, 1'b0, 1'b0, hub);
        rq(32'h0ff7ffff, src_processor, 1'b0, 1'b0, dram);
        wr(8'h9e, 8'h07);
        rq(32'h0ff7ffff, src_processor, 1'b0, 1'b0, hub);
        wr(8'h9e, 8'h06);
        rq(32'h0ff80000, src_processor, 1'b0, 1'b0, dram);
    endtask
    task automatic lock_down;
        wr(8'h9e, 8'hc5);
        wr(8'h9d, 8'h48);
        wr(8'h9d, 8'h08);
        wr(8'h9d, 8'h18);
        rd(8'h9d, 8'h1a);
        wr(8'h9d, 8'h48);
        rd(8'h9d, 8'h1a);
        rq(32'h000a0000, src_processor, 1'b0, 1'b0, hub);
        wr(8'h9d, 8'h00);
        rd(8'h9d, 8'h1a);
        wr(8'h9e, 8'h00);
        rd(8'h9e, 8'hbd);
        @(negedge i_clock);
        i_reset = 1'b1;
        repeat (2) @(negedge i_clock);
        i_reset = 1'b0;
        rd(8'h9d, 8'h02);
    endtask
    task automatic give_verdict;
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge i_clock);
        i_reset = 1'b0;
        reset_values();
        global_gate();
        open_closed();
        high_window();
        top_segment();
        lock_down();
        give_verdict();
    end
endmodule // test_smm_ram_access_control
`default_nettype wire
